// ===== irtx_top.sv
// Implementation choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
// Behaviour
// - Timer carrier gated by bit sequence drives pin
// - Timer clock is clk over two-to-index
// - Carrier low until rise count elapses
// - Period count ends carrier cycle, goes low
// - Each bit lasts 1 to 256 carriers
// - Invert select flips the output polarity
// - End of transmission interrupt when enabled
// - Sequence fetched as consecutive 32-bit words
// - Send exactly programmed count, 1 to 4096
// - Invalid start refused, nothing begins
// - Busy flag true during a transmission
// - Disable leaves infrared transmission mode
module irtx_top (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Avalon-MM slave
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // Emitter pin and interrupt
   output logic             ir_out,
   output logic             ir_out_en,
   output logic             irq
);

   // ---------------------------------------------------------------
   // Bus handshake
   // ---------------------------------------------------------------
   logic        wait_reg;                       // Waitrequest flop
   logic [31:0] rdata_reg;                      // Read data flop
   wire         wait_next = ~((avs_read | avs_write) & wait_reg);
   wire         wr_go     = avs_write & ~wait_reg;   // Write lands here
   wire         rd_go     = avs_read & wait_reg;     // Read data captured
   wire         is_mem    = avs_address[irtx_pkg::MEM_SEL];
   wire         ctrl_wr   = wr_go & ~is_mem & (avs_address == irtx_pkg::OFS_CTRL);
   wire         car_wr    = wr_go & ~is_mem & (avs_address == irtx_pkg::OFS_CARRIER);
   wire         blen_wr   = wr_go & ~is_mem & (avs_address == irtx_pkg::OFS_BITLEN);
   wire         start_wr  = wr_go & ~is_mem & (avs_address == irtx_pkg::OFS_START);
   wire         clr_wr    = wr_go & ~is_mem & (avs_address == irtx_pkg::OFS_IRQ_CLR);
   wire         en_wr     = wr_go & ~is_mem & (avs_address == irtx_pkg::OFS_IRQ_EN);
   wire         mem_wr    = wr_go & is_mem;

   // ---------------------------------------------------------------
   // Configuration and control state
   // ---------------------------------------------------------------
   logic                   mode_reg;            // Infrared mode on
   irtx_pkg::irtx_cfg_t    cfg_reg;             // Carrier and bit setup
   logic                   refused_reg;         // Last request refused
   logic [1:0]             irq_st_reg;          // Sticky events
   logic [1:0]             irq_en_reg;          // Event enables
   irtx_pkg::irtx_state_t  state_reg;           // Sequencer state
   irtx_pkg::irtx_state_t  state_next;
   irtx_pkg::irtx_start_t  req;                 // Start fields as written

   assign req.sequence_bit_count =
      avs_writedata[irtx_pkg::START_CNT_LSB +: 13];
   assign req.sequence_buffer_pointer =
      avs_writedata[irtx_pkg::START_PTR_LSB +: 7];

   wire [4:0] new_idx  = avs_writedata[irtx_pkg::CTRL_IDX_LSB +: 5];
   wire       want_en  = avs_writedata[irtx_pkg::CTRL_EN_BIT];
   wire       end_irq_enable = irq_en_reg[irtx_pkg::IRQ_DONE_BIT];

   // Timing setup is legal only with a reachable rise and a nonzero bit
   wire timing_ok = (cfg_reg.carrier_period_count != 16'h0000)
                  & (cfg_reg.carrier_rise_count < cfg_reg.carrier_period_count)
                  & (cfg_reg.bit_length_in_carriers != 9'h000)
                  & (cfg_reg.bit_length_in_carriers <= irtx_pkg::MAX_BITLEN);
   wire ctrl_bad = want_en & (~timing_ok | (new_idx > irtx_pkg::MAX_IDX));
   wire ctrl_ok  = ctrl_wr & ~ctrl_bad;

   // Start is taken only in mode, idle, with a legal length
   wire cnt_ok   = (req.sequence_bit_count != 13'h0000)
                 & (req.sequence_bit_count <= irtx_pkg::MAX_BITS);
   wire start_ok = start_wr & mode_reg & timing_ok & cnt_ok
                 & (state_reg == irtx_pkg::ST_IDLE);
   wire refuse   = (start_wr & ~start_ok) | (ctrl_wr & ctrl_bad);

   // ---------------------------------------------------------------
   // Prescaler, carrier and bit timing
   // ---------------------------------------------------------------
   logic [16:0] presc_reg;                      // Peripheral clock counter
   logic [15:0] car_cnt_reg;                    // Timer clocks in carrier
   logic [8:0]  bit_car_reg;                    // Carriers in current bit
   logic [12:0] bits_left_reg;                  // Bits still to send
   logic [4:0]  bit_pos_reg;                    // Bit within current word
   logic [31:0] word_reg;                       // Word being shifted out
   logic [6:0]  fetch_addr_reg;                 // Next word to read
   logic [31:0] mem_rdata;                      // Store read data

   wire         sending = (state_reg == irtx_pkg::ST_SEND);
   wire [16:0]  presc_mask = 17'((17'h00001 << cfg_reg.clock_divide_index) - 17'h00001);
   wire         tick    = sending & (presc_reg == presc_mask);
   wire         per_end = tick & (car_cnt_reg ==
                          16'(cfg_reg.carrier_period_count - 16'h0001));
   wire         bit_end = per_end & (bit_car_reg ==
                          9'(cfg_reg.bit_length_in_carriers - 9'h001));
   wire         last_bit = bit_end & (bits_left_reg == 13'h0001);
   wire         word_end = bit_end & (bit_pos_reg == 5'h1F);
   wire         carrier  = (car_cnt_reg >= cfg_reg.carrier_rise_count);
   wire         cur_bit  = word_reg[bit_pos_reg];
   wire         disable_req = ctrl_wr & ~want_en;

   // Counter next values
   wire [16:0] presc_next = ~sending ? 17'h00000 :
                            tick ? 17'h00000 : 17'(presc_reg + 17'h00001);
   wire [15:0] car_next   = ~sending ? 16'h0000 :
                            per_end ? 16'h0000 :
                            tick ? 16'(car_cnt_reg + 16'h0001) : car_cnt_reg;
   wire [8:0]  bcar_next  = ~sending ? 9'h000 :
                            bit_end ? 9'h000 :
                            per_end ? 9'(bit_car_reg + 9'h001) : bit_car_reg;

   // Sequencer next state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         irtx_pkg::ST_IDLE: begin
            if (start_ok) begin
               state_next = irtx_pkg::ST_LOAD;
            end
         end
         irtx_pkg::ST_LOAD: begin
            state_next = irtx_pkg::ST_LATCH;   // Store read in flight
         end
         irtx_pkg::ST_LATCH: begin
            state_next = irtx_pkg::ST_SEND;
         end
         irtx_pkg::ST_SEND: begin
            if (last_bit) begin
               state_next = irtx_pkg::ST_IDLE;
            end
         end
         default: begin
            state_next = irtx_pkg::ST_IDLE;
         end
      endcase
      if (disable_req) begin
         state_next = irtx_pkg::ST_IDLE;
      end
   end

   // ---------------------------------------------------------------
   // Events and outputs
   // ---------------------------------------------------------------
   wire        done_evt = sending & last_bit & ~disable_req;
   wire [1:0]  irq_set  = {refuse, done_evt};
   wire [1:0]  irq_clr  = clr_wr ? avs_writedata[1:0] : 2'h0;
   wire [1:0]  irq_st_next = (irq_st_reg & ~irq_clr) | irq_set;
   wire        ir_next  = sending ? ((carrier & cur_bit)
                          ^ cfg_reg.output_invert_select)
                          : cfg_reg.output_invert_select;

   // Register read selection
   wire [31:0] rd_mux =
      is_mem ? 32'h00000000 :
      (avs_address == irtx_pkg::OFS_CTRL) ? {19'h00000,
         cfg_reg.clock_divide_index, 6'h00,
         cfg_reg.output_invert_select, mode_reg} :
      (avs_address == irtx_pkg::OFS_CARRIER) ? {cfg_reg.carrier_period_count,
         cfg_reg.carrier_rise_count} :
      (avs_address == irtx_pkg::OFS_BITLEN) ? {23'h000000,
         cfg_reg.bit_length_in_carriers} :
      (avs_address == irtx_pkg::OFS_STATUS) ? {30'h00000000, refused_reg,
         (state_reg != irtx_pkg::ST_IDLE)} :
      (avs_address == irtx_pkg::OFS_IRQ_ST) ? {30'h00000000, irq_st_reg} :
      (avs_address == irtx_pkg::OFS_IRQ_EN) ? {30'h00000000, irq_en_reg} :
      32'h00000000;

   // ---------------------------------------------------------------
   // Sequence store
   // ---------------------------------------------------------------
   irtx_seq_mem #(
      .WORDS (irtx_pkg::MEM_WORDS),
      .AW    (irtx_pkg::MEM_AW),
      .DW    (irtx_pkg::DATA_W)
   ) u_mem (
      .clk     (clk),
      .rst     (rst),
      .wr_en   (mem_wr),
      .wr_addr (avs_address[irtx_pkg::MEM_AW-1:0]),
      .wr_data (avs_writedata),
      .rd_addr (fetch_addr_reg),
      .rd_data (mem_rdata)
   );

   // ---------------------------------------------------------------
   // Flops
   // ---------------------------------------------------------------
   // Bus flops
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wait_reg  <= 1'b1;
         rdata_reg <= 32'h00000000;
      end else begin
         wait_reg <= wait_next;
         if (rd_go) begin
            rdata_reg <= rd_mux;
         end
      end
   end

   // Configuration flops
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mode_reg <= 1'b0;
         cfg_reg  <= '0;
      end else begin
         if (ctrl_ok) begin
            mode_reg <= want_en;
            cfg_reg.output_invert_select <= avs_writedata[irtx_pkg::CTRL_INV_BIT];
            cfg_reg.clock_divide_index   <= new_idx;
         end
         if (car_wr) begin
            cfg_reg.carrier_rise_count   <= avs_writedata[irtx_pkg::CAR_RISE_LSB +: 16];
            cfg_reg.carrier_period_count <= avs_writedata[irtx_pkg::CAR_PER_LSB +: 16];
         end
         if (blen_wr) begin
            cfg_reg.bit_length_in_carriers <= avs_writedata[8:0];
         end
      end
   end

   // Event flops
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_st_reg  <= 2'h0;
         irq_en_reg  <= 2'h0;
         refused_reg <= 1'b0;
      end else begin
         irq_st_reg <= irq_st_next;
         if (en_wr) begin
            irq_en_reg <= avs_writedata[1:0];
         end
         if (start_wr | ctrl_wr) begin
            refused_reg <= refuse;
         end
      end
   end

   // Timing counter flops
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg   <= irtx_pkg::ST_IDLE;
         presc_reg   <= 17'h00000;
         car_cnt_reg <= 16'h0000;
         bit_car_reg <= 9'h000;
      end else begin
         state_reg   <= state_next;
         presc_reg   <= presc_next;
         car_cnt_reg <= car_next;
         bit_car_reg <= bcar_next;
      end
   end

   // Word fetch and bit stepping
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bits_left_reg  <= 13'h0000;
         bit_pos_reg    <= 5'h00;
         word_reg       <= 32'h00000000;
         fetch_addr_reg <= 7'h00;
      end else if (start_ok) begin
         bits_left_reg  <= req.sequence_bit_count;
         fetch_addr_reg <= req.sequence_buffer_pointer;
      end else if (state_reg == irtx_pkg::ST_LATCH || word_end) begin
         word_reg       <= mem_rdata;
         fetch_addr_reg <= 7'(fetch_addr_reg + 7'h01);
         bit_pos_reg    <= 5'h00;
         if (word_end) begin
            bits_left_reg <= 13'(bits_left_reg - 13'h0001);
         end
      end else if (bit_end) begin
         bits_left_reg <= 13'(bits_left_reg - 13'h0001);
         bit_pos_reg   <= 5'(bit_pos_reg + 5'h01);
      end
   end

   // Output flops
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ir_out    <= 1'b0;
         ir_out_en <= 1'b0;
         irq       <= 1'b0;
      end else begin
         ir_out    <= ir_next;
         ir_out_en <= mode_reg;
         irq       <= |(irq_st_reg & irq_en_reg);
      end
   end

   assign avs_waitrequest = wait_reg;
   assign avs_readdata    = rdata_reg;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   a_presc_half_rate: assert property (
      (tick && cfg_reg.clock_divide_index == 5'h01 && !ctrl_wr) |=> !tick)
      else $error("prescale index one ticked twice in a row");
   a_carrier_low: assert property (
      (sending && car_cnt_reg < cfg_reg.carrier_rise_count
       && !cfg_reg.output_invert_select && !ctrl_wr) |=> !ir_out)
      else $error("carrier high before rise count");
   a_carrier_period: assert property (
      sending |-> car_cnt_reg < cfg_reg.carrier_period_count)
      else $error("carrier count passed period");
   a_bit_length: assert property (
      sending |-> bit_car_reg < cfg_reg.bit_length_in_carriers)
      else $error("bit ran past its carrier count");
   a_idle_polarity: assert property (
      (state_reg == irtx_pkg::ST_IDLE && !ctrl_wr)
      |=> ir_out == $past(cfg_reg.output_invert_select))
      else $error("idle output not at inactive level");
   a_done_sticky: assert property (
      done_evt |=> irq_st_reg[irtx_pkg::IRQ_DONE_BIT] ##1
      (irq == (end_irq_enable || $past(irq_st_reg[irtx_pkg::IRQ_REF_BIT]
                                       && irq_en_reg[irtx_pkg::IRQ_REF_BIT]))
       || $past(en_wr)))
      else $error("end event not flagged or gated");
   a_bits_remain: assert property (
      sending |-> bits_left_reg != 13'h0000)
      else $error("sending with no bits left");
   a_refuse_start: assert property (
      (start_wr && !start_ok && state_reg == irtx_pkg::ST_IDLE)
      |=> state_reg == irtx_pkg::ST_IDLE ##0 refused_reg)
      else $error("refused start began a transmission");
   a_zero_bit: assert property (
      (sending && !cur_bit && !cfg_reg.output_invert_select && !ctrl_wr)
      |=> !ir_out)
      else $error("zero bit drove the output");
   a_disable_stop: assert property (
      disable_req |=> state_reg == irtx_pkg::ST_IDLE && !mode_reg)
      else $error("disable left mode running");

endmodule

// ===== irtx_pkg.sv
// ---------------------------------------------------------------
// Register map, field layout and shared types
// ---------------------------------------------------------------
package irtx_pkg;

   // Bus geometry
   localparam int ADDR_W    = 8;                 // Word address width
   localparam int DATA_W    = 32;                // Data width
   localparam int MEM_WORDS = 128;               // Sequence store depth
   localparam int MEM_AW    = 7;                 // Sequence store address width
   localparam int MEM_SEL   = 7;                 // Address bit selecting the store

   // Register word offsets
   localparam logic [7:0] OFS_CTRL    = 8'h00;   // Mode, polarity, prescale
   localparam logic [7:0] OFS_CARRIER = 8'h01;   // Rise and period counts
   localparam logic [7:0] OFS_BITLEN  = 8'h02;   // Bit length in carriers
   localparam logic [7:0] OFS_START   = 8'h03;   // Start request
   localparam logic [7:0] OFS_STATUS  = 8'h04;   // Busy and refusal state
   localparam logic [7:0] OFS_IRQ_ST  = 8'h05;   // Sticky events, read only
   localparam logic [7:0] OFS_IRQ_CLR = 8'h06;   // Event clear, write only
   localparam logic [7:0] OFS_IRQ_EN  = 8'h07;   // Event enable

   // Field positions
   localparam int CTRL_EN_BIT   = 0;             // Infrared mode enable
   localparam int CTRL_INV_BIT  = 1;             // Output inversion
   localparam int CTRL_IDX_LSB  = 8;             // Prescale index, 5 bits
   localparam int CAR_RISE_LSB  = 0;             // Rise count, 16 bits
   localparam int CAR_PER_LSB   = 16;            // Period count, 16 bits
   localparam int START_CNT_LSB = 0;             // Bit count, 13 bits
   localparam int START_PTR_LSB = 16;            // Word pointer, 7 bits
   localparam int STAT_BUSY_BIT = 0;             // Transmission in progress
   localparam int STAT_REF_BIT  = 1;             // Last request refused
   localparam int IRQ_DONE_BIT  = 0;             // End of transmission
   localparam int IRQ_REF_BIT   = 1;             // Request refused
   localparam int IRQ_W         = 2;             // Event count

   // Legal ranges
   localparam logic [4:0]  MAX_IDX    = 5'h10;   // Largest prescale index
   localparam logic [8:0]  MAX_BITLEN = 9'h100;  // Largest bit length
   localparam logic [12:0] MAX_BITS   = 13'h1000;// Largest transmission

   // Carrier and bit configuration
   typedef struct packed {
      logic        output_invert_select;
      logic [4:0]  clock_divide_index;
      logic [15:0] carrier_rise_count;
      logic [15:0] carrier_period_count;
      logic [8:0]  bit_length_in_carriers;
   } irtx_cfg_t;

   // Start request fields
   typedef struct packed {
      logic [12:0] sequence_bit_count;
      logic [6:0]  sequence_buffer_pointer;
   } irtx_start_t;

   // Transmit sequencer states
   typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_LATCH, ST_SEND} irtx_state_t;

endpackage

// ===== irtx_seq_mem.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Sequence word store, registered read
// ---------------------------------------------------------------
module irtx_seq_mem #(
   parameter int WORDS = 128,
   parameter int AW    = 7,
   parameter int DW    = 32
) (
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          rst,
   // Write side
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic [DW-1:0] wr_data,
   // Read side
   input  wire logic [AW-1:0] rd_addr,
   output logic      [DW-1:0] rd_data
);

   logic [DW-1:0] mem_array [WORDS];   // Storage words

   // Write port, no reset on the array
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem_array[wr_addr] <= wr_data;
      end
   end

   // Read data leaves from a register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_data <= '0;
      end else begin
         rd_data <= mem_array[rd_addr];
      end
   end

endmodule

// ===== irtx_emitter.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Emitter model: counts light pulses and measures their width
// ---------------------------------------------------------------
module irtx_emitter (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Pin from the transmitter
   input  wire logic ir_out,
   input  wire logic ir_out_en,
   // Bench control and results
   input  wire logic clear,
   output int        pulses,
   output int        width
);
   logic lit;      // Emitter driven and on
   logic prev;     // Previous light level
   int   run;      // Length of current light run

   assign lit = ir_out & ir_out_en;

   // Light only while the pin is driven; count rising edges, keep last width
   always @(posedge clk or posedge rst) begin
      if (rst || clear) begin
         prev   <= 1'b0;
         pulses <= 0;
         width  <= 0;
         run    <= 0;
      end else begin
         prev <= lit;
         run  <= lit ? run + 1 : 0;
         if (lit && !prev) pulses <= pulses + 1;
         if (!lit && prev) width <= run;
      end
   end
endmodule

// ===== irtx_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
   $display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, b); end end
// ---------------------------------------------------------------
// Self-checking bench for the infrared transmitter
// ---------------------------------------------------------------
module irtx_bench;
   logic        clk, rst;                    // Clock and reset
   logic [7:0]  avs_address;                 // Bus word address
   logic        avs_read, avs_write;         // Bus strobes
   logic [31:0] avs_writedata, avs_readdata; // Bus data
   logic        avs_waitrequest;             // Bus stall
   logic        ir_out, ir_out_en, irq;      // Pin and interrupt
   logic        emit_clear;                  // Emitter counter clear
   int          pulses, width;               // Emitter results
   int          errors, checked, cycles;     // Counters
   logic [31:0] rd;                          // Read scratch
   // Readback rows: address, write data, expected read
   logic [7:0]  row_a [6] = '{8'h01, 8'h02, 8'h07, 8'h08, 8'h05, 8'h80};
   logic [31:0] row_w [6] = '{32'h0002_0001, 32'h1, 32'h3, 32'hFFFF_FFFF, 32'h3, 32'hA5};
   logic [31:0] row_e [6] = '{32'h0002_0001, 32'h1, 32'h3, 32'h0, 32'h0, 32'h0};

   irtx_top irtx_top_inst (.clk(clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .ir_out(ir_out), .ir_out_en(ir_out_en), .irq(irq));
   irtx_emitter irtx_emitter_inst (.clk(clk), .rst(rst), .ir_out(ir_out),
      .ir_out_en(ir_out_en), .clear(emit_clear), .pulses(pulses), .width(width));

   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         errors++;
         wrap_up();
      end
   end

   // Verdict and end of run
   task automatic wrap_up();
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // One bus cycle, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= !wr;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask

   // Poll the status word until the transmission ends
   task automatic wait_idle();
      do bus(1'b0, irtx_pkg::OFS_STATUS, 32'h0); while (rd[0] !== 1'b0);
   endtask

   initial begin
      errors = 0; checked = 0; cycles = 0; rst = 1'b1; emit_clear = 1'b0;
      avs_address = 8'h00; avs_read = 1'b0; avs_write = 1'b0; avs_writedata = 32'h0;
      repeat (11) @(posedge clk);
      `CHK({avs_waitrequest, irq, ir_out_en, ir_out}, 4'h8)
      @(posedge clk) rst <= 1'b0;
      // Register readback table
      for (int i = 0; i < 6; i++) begin
         bus(1'b1, row_a[i], row_w[i]);
         bus(1'b0, row_a[i], 32'h0);
         `CHK(rd, row_e[i])
      end
      // Sequence store: words 0..2
      bus(1'b1, 8'h80, 32'h3);
      bus(1'b1, 8'h81, 32'h1);
      bus(1'b1, 8'h82, 32'h1);
      // Enable with bit length 257 is refused
      bus(1'b1, irtx_pkg::OFS_BITLEN, 32'h101);
      bus(1'b1, irtx_pkg::OFS_CTRL, 32'h1);
      bus(1'b0, irtx_pkg::OFS_STATUS, 32'h0);
      `CHK({rd[1:0], ir_out_en, irq}, 4'h9)
      // Legal setup: index 0, rise 1, period 2, one carrier per bit
      bus(1'b1, irtx_pkg::OFS_BITLEN, 32'h1);
      bus(1'b1, irtx_pkg::OFS_IRQ_CLR, 32'h3);
      bus(1'b1, irtx_pkg::OFS_IRQ_EN, 32'h1);
      bus(1'b1, irtx_pkg::OFS_CTRL, 32'h1);
      // Prescale index 17 is refused, mode and index kept
      bus(1'b1, irtx_pkg::OFS_CTRL, 32'h1101);
      bus(1'b0, irtx_pkg::OFS_CTRL, 32'h0);
      `CHK(rd, 32'h1)
      // Starts with 0 and 4097 bits are refused, no interrupt
      bus(1'b1, irtx_pkg::OFS_START, 32'h0);
      bus(1'b1, irtx_pkg::OFS_START, 32'h1001);
      bus(1'b0, irtx_pkg::OFS_STATUS, 32'h0);
      `CHK({rd[1:0], ir_out_en, irq}, 4'hA)
      bus(1'b0, irtx_pkg::OFS_IRQ_ST, 32'h0);
      `CHK(rd[1:0], 2'h2)
      bus(1'b1, irtx_pkg::OFS_IRQ_CLR, 32'h3);
      // 34 bits crossing words 0 and 1: ones at bits 0, 1, 32
      @(posedge clk) emit_clear <= 1'b1;
      @(posedge clk) emit_clear <= 1'b0;
      bus(1'b1, irtx_pkg::OFS_START, 32'h0000_0022);
      bus(1'b0, irtx_pkg::OFS_STATUS, 32'h0);
      `CHK(rd[0], 1'b1)
      `CHK(irq, 1'b0)
      wait_idle();
      `CHK(pulses, 3)
      `CHK(width, 1)
      `CHK(irq, 1'b1)
      bus(1'b1, irtx_pkg::OFS_IRQ_CLR, 32'h1);
      repeat (3) @(posedge clk);
      `CHK(irq, 1'b0)
      // Disable, then index 1, rise 1, period 3, two carriers per bit
      bus(1'b1, irtx_pkg::OFS_CTRL, 32'h0);
      repeat (2) @(posedge clk);
      `CHK(ir_out_en, 1'b0)
      bus(1'b1, irtx_pkg::OFS_CARRIER, 32'h0003_0001);
      bus(1'b1, irtx_pkg::OFS_BITLEN, 32'h2);
      bus(1'b1, irtx_pkg::OFS_CTRL, 32'h101);
      @(posedge clk) emit_clear <= 1'b1;
      @(posedge clk) emit_clear <= 1'b0;
      bus(1'b1, irtx_pkg::OFS_START, 32'h0002_0001);
      wait_idle();
      `CHK(pulses, 2)
      `CHK(width, 4)
      // Inverted idle level, then abort a long run by disabling
      bus(1'b1, irtx_pkg::OFS_IRQ_CLR, 32'h3);
      bus(1'b1, irtx_pkg::OFS_CTRL, 32'h3);
      repeat (2) @(posedge clk);
      `CHK(ir_out, 1'b1)
      bus(1'b1, irtx_pkg::OFS_START, 32'h1000);
      repeat (20) @(posedge clk);
      bus(1'b1, irtx_pkg::OFS_CTRL, 32'h0);
      bus(1'b0, irtx_pkg::OFS_STATUS, 32'h0);
      `CHK(rd[0], 1'b0)
      bus(1'b0, irtx_pkg::OFS_IRQ_ST, 32'h0);
      `CHK({rd[0], irq}, 2'h0)
      // Reset in mid-transmission returns everything to idle
      bus(1'b1, irtx_pkg::OFS_CTRL, 32'h1);
      bus(1'b1, irtx_pkg::OFS_START, 32'h1000);
      repeat (10) @(posedge clk);
      @(posedge clk) rst <= 1'b1;
      repeat (2) @(posedge clk);
      `CHK({avs_waitrequest, irq, ir_out_en, ir_out}, 4'h8)
      @(posedge clk) rst <= 1'b0;
      bus(1'b0, irtx_pkg::OFS_STATUS, 32'h0);
      `CHK(rd[1:0], 2'h0)
      bus(1'b0, irtx_pkg::OFS_CTRL, 32'h0);
      `CHK(rd, 32'h0)
      wrap_up();
   end
endmodule
